//--- sco_host.sv
// sco_host: management-bus host model issuing byte-wide register reads and writes.
// assumes requests are launched on the falling edge and taken on the next rising edge.
`timescale 1ns/1ps
module sco_host (
    input  wire logic         ref_clk,
    output sco_pkg::sco_req_t req,
    input  wire logic [7:0]   rd_data,
    input  wire logic         rd_valid
);
    import sco_pkg::*;

    initial req = '0;

    // one-cycle strobe; address and data are scrambled once released
    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge ref_clk);
        req.addr  = addr;
        req.wdata = data;
        req.wr    = 1'b1;
        @(negedge ref_clk);
        req.wr    = 1'b0;
        req.addr  = ~addr;
        req.wdata = ~data;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data,
                          output logic ok);
        @(negedge ref_clk);
        req.addr = addr;
        req.rd   = 1'b1;
        @(negedge ref_clk);
        req.rd   = 1'b0;
        req.addr = ~addr;
        ok       = 1'b0;
        data     = 8'h00;
        // bounded wait so a missing answer cannot hang the run
        for (int i = 0; i < 3 && !ok; i++) begin
            if (rd_valid === 1'b1) begin
                ok   = 1'b1;
                data = rd_data;
            end else begin
                @(negedge ref_clk);
            end
        end
    endtask : rd_reg
endmodule : sco_host

//--- sco_pkg.sv
// sco_pkg: shared constants and carrier types of the serializer configuration register bank.
// assumes a management-bus front end that hands over decoded byte-wide register accesses.
// Behaviour
// R1: nrzi coding follows config bit 7 only while its unlock bit is set
// R2: config bit 6 high suppresses payload valid signaling, low provides it
// R3: scrambler follows config bit 4 only while its unlock bit is set
// R4: encoder bypass follows config bit 3 only while its unlock bit is set
// R5: training sequence follows config bit 2 only while its unlock bit is set
// R6: config bits 1:0 are active-low remote sense and encoder enables, pins otherwise
// R7: unlock bit 0 takes config bits 1:0 from the register instead of pins
// R8: unlock bits 4,3,2,1 unlock nrzi, scrambler, encoder bypass, training sequence
// R9: locked config bits still store writes; effective setting stays at pin/default
// R10: clock-delay bit 7 low inserts parallel clock delay, high bypasses it
// R11: power-down bit 7 written one resets the channel, then clears itself
// R12: power-down bit 6 powers down parallel, serializer and always-on clocks
// R13: power-down bit 5 enables the parallel clock receiver, resets to one
// R14: power-down bits 4:0 enable data lanes 4:0, each resets to one
// R15: config, unlock and clock-delay fields reset to zero
// R16: de-emphasis bit 2 selects register level when one, pin level when zero
package sco_pkg;

    localparam int unsigned LANES = 5;

    // register offsets
    localparam logic [7:0] ADDR_DEEMPH = 8'h20;
    localparam logic [7:0] ADDR_CODING = 8'h21;
    localparam logic [7:0] ADDR_UNLOCK = 8'h22;
    localparam logic [7:0] ADDR_CLKDLY = 8'h24;
    localparam logic [7:0] ADDR_PWR    = 8'h26;

    // link_coding_config fields
    localparam int unsigned CFG_NRZI   = 7;
    localparam int unsigned CFG_VALID_OFF = 6;
    localparam int unsigned CFG_SCRAM  = 4;
    localparam int unsigned CFG_BYP    = 3;
    localparam int unsigned CFG_TRAIN  = 2;
    localparam int unsigned CFG_PINS_HI = 1;

    // config_unlock_mask fields
    localparam int unsigned UNL_NRZI  = 4;
    localparam int unsigned UNL_SCRAM = 3;
    localparam int unsigned UNL_BYP   = 2;
    localparam int unsigned UNL_TRAIN = 1;
    localparam int unsigned UNL_PINS  = 0;

    // other fields
    localparam int unsigned DLY_BYP   = 7;
    localparam int unsigned PWR_CHRST = 7;
    localparam int unsigned PWR_CLKPD = 6;
    localparam int unsigned PWR_PCLK  = 5;
    localparam int unsigned DEM_OVR   = 2;

    // writable bits; the rest read as zero
    localparam logic [7:0] MASK_DEEMPH = 8'h07;
    localparam logic [7:0] MASK_CODING = 8'hFF;
    localparam logic [7:0] MASK_UNLOCK = 8'h1F;
    localparam logic [7:0] MASK_CLKDLY = 8'h80;
    localparam logic [7:0] MASK_PWR    = 8'hFF;

    // reset values
    localparam logic [7:0] RST_DEEMPH = 8'h00;
    localparam logic [7:0] RST_CODING = 8'h00;
    localparam logic [7:0] RST_UNLOCK = 8'h00;
    localparam logic [7:0] RST_CLKDLY = 8'h00;
    localparam logic [7:0] RST_PWR    = 8'h3F;
    localparam logic [7:0] RD_NONE    = 8'h00;

    // value of a register-only coding setting while it is locked
    localparam logic DEF_CODING_OFF = 1'b0;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sco_req_t;

    typedef struct packed {
        logic             nrzi_en;
        logic             payload_valid_signal_en;
        logic             scrambler_en;
        logic             encoder_bypass;
        logic             training_en;
        logic             remote_sense_en_n;
        logic             dc_encoder_en_n;
        logic             clock_delay_bypass;
        logic             channel_reset;
        logic             clock_power_down;
        logic             parallel_clock_input_en;
        logic [LANES-1:0] parallel_data_lane_en;
        logic [1:0]       deemph_level;
    } sco_eff_t;

endpackage : sco_pkg

//--- sco_regs.sv
// sco_regs: configuration, unlock, clock-delay, power-down and de-emphasis registers
// with effective-setting selection for a parallel-to-serial link transmitter.
// assumes an upstream management-bus front end delivering one-cycle read/write strobes.
`timescale 1ns/1ps
module sco_regs (
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    input  wire logic                   ce,
    input  wire sco_pkg::sco_req_t      req,
    input  wire logic [1:0]             cfg_pins_async,
    input  wire logic [1:0]             deemph_pins_async,
    output logic [7:0]                  rd_data,
    output logic                        rd_valid,
    output sco_pkg::sco_eff_t           settings
);
    import sco_pkg::*;

    logic [7:0] dem_ff;
    logic [7:0] cod_ff;
    logic [7:0] unl_ff;
    logic [7:0] dly_ff;
    logic [7:0] pwr_ff;
    logic [7:0] rd_data_ff;
    logic       rd_valid_ff;
    sco_eff_t   eff_ff;

    logic [7:0] nxt_dem;
    logic [7:0] nxt_cod;
    logic [7:0] nxt_unl;
    logic [7:0] nxt_dly;
    logic [7:0] nxt_pwr;
    logic [7:0] nxt_rd_data;

    logic [3:0] pins_sync;
    logic [1:0] cfg_pins;
    logic [1:0] dem_pins;

    // a net, since the selectors and the assigns each drive their own fields
    wire sco_eff_t nxt_eff;

    // address decode
    wire hit_dem = (req.addr == ADDR_DEEMPH);
    wire hit_cod = (req.addr == ADDR_CODING);
    wire hit_unl = (req.addr == ADDR_UNLOCK);
    wire hit_dly = (req.addr == ADDR_CLKDLY);
    wire hit_pwr = (req.addr == ADDR_PWR);
    wire hit_any = hit_dem | hit_cod | hit_unl | hit_dly | hit_pwr;

    wire wr_dem = req.wr & hit_dem;
    wire wr_cod = req.wr & hit_cod;
    wire wr_unl = req.wr & hit_unl;
    wire wr_dly = req.wr & hit_dly;
    wire wr_pwr = req.wr & hit_pwr;

    sco_sync #(
        .W (4)
    ) u_pin_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .ce      (ce),
        .din     ({cfg_pins_async, deemph_pins_async}),
        .dout    (pins_sync)
    );

    assign cfg_pins = pins_sync[3:2];
    assign dem_pins = pins_sync[1:0];

    // locked bits still take writes so software can stage before unlocking
    assign nxt_cod = wr_cod ? (req.wdata & MASK_CODING) : cod_ff; // see R9
    assign nxt_unl = wr_unl ? (req.wdata & MASK_UNLOCK) : unl_ff;
    assign nxt_dly = wr_dly ? (req.wdata & MASK_CLKDLY) : dly_ff;
    assign nxt_dem = wr_dem ? (req.wdata & MASK_DEEMPH) : dem_ff;

    // channel reset lasts one enabled cycle; a new write re-arms it
    assign nxt_pwr = wr_pwr ? (req.wdata & MASK_PWR)
                            : {1'b0, pwr_ff[PWR_CHRST-1:0]}; // see R11

    assign nxt_rd_data = hit_dem ? dem_ff :
                         hit_cod ? cod_ff :
                         hit_unl ? unl_ff :
                         hit_dly ? dly_ff :
                         hit_pwr ? pwr_ff : RD_NONE;

    // effective-setting selection
    sco_select #(
        .W (1)
    ) u_sel_nrzi (
        .unlock  (unl_ff[UNL_NRZI]),
        .reg_val (cod_ff[CFG_NRZI]),
        .pin_val (DEF_CODING_OFF),
        .eff_val (nxt_eff.nrzi_en)
    ); // see R1 see R8

    sco_select #(
        .W (1)
    ) u_sel_scram (
        .unlock  (unl_ff[UNL_SCRAM]),
        .reg_val (cod_ff[CFG_SCRAM]),
        .pin_val (DEF_CODING_OFF),
        .eff_val (nxt_eff.scrambler_en)
    ); // see R3 see R8

    sco_select #(
        .W (1)
    ) u_sel_byp (
        .unlock  (unl_ff[UNL_BYP]),
        .reg_val (cod_ff[CFG_BYP]),
        .pin_val (DEF_CODING_OFF),
        .eff_val (nxt_eff.encoder_bypass)
    ); // see R4 see R8

    sco_select #(
        .W (1)
    ) u_sel_train (
        .unlock  (unl_ff[UNL_TRAIN]),
        .reg_val (cod_ff[CFG_TRAIN]),
        .pin_val (DEF_CODING_OFF),
        .eff_val (nxt_eff.training_en)
    ); // see R5 see R8

    sco_select #(
        .W (2)
    ) u_sel_pins (
        .unlock  (unl_ff[UNL_PINS]),
        .reg_val (cod_ff[CFG_PINS_HI:0]),
        .pin_val (cfg_pins),
        .eff_val ({nxt_eff.remote_sense_en_n, nxt_eff.dc_encoder_en_n})
    ); // see R6 see R7

    sco_select #(
        .W (2)
    ) u_sel_dem (
        .unlock  (dem_ff[DEM_OVR]),
        .reg_val (dem_ff[1:0]),
        .pin_val (dem_pins),
        .eff_val (nxt_eff.deemph_level)
    ); // see R16

    assign nxt_eff.payload_valid_signal_en = ~cod_ff[CFG_VALID_OFF]; // see R2
    assign nxt_eff.clock_delay_bypass      = dly_ff[DLY_BYP]; // see R10
    assign nxt_eff.channel_reset           = pwr_ff[PWR_CHRST]; // see R11
    assign nxt_eff.clock_power_down        = pwr_ff[PWR_CLKPD]; // see R12
    assign nxt_eff.parallel_clock_input_en = pwr_ff[PWR_PCLK]; // see R13
    assign nxt_eff.parallel_data_lane_en   = pwr_ff[LANES-1:0]; // see R14

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dem_ff <= RST_DEEMPH;
            cod_ff <= RST_CODING; // see R15
            unl_ff <= RST_UNLOCK; // see R15
            dly_ff <= RST_CLKDLY; // see R15
            pwr_ff <= RST_PWR; // see R13 see R14
        end else if (ce) begin
            dem_ff <= nxt_dem;
            cod_ff <= nxt_cod;
            unl_ff <= nxt_unl;
            dly_ff <= nxt_dly;
            pwr_ff <= nxt_pwr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_data_ff  <= RD_NONE;
            rd_valid_ff <= 1'b0;
        end else if (ce) begin
            rd_data_ff  <= req.rd ? nxt_rd_data : rd_data_ff;
            rd_valid_ff <= req.rd;
        end
    end

    // effective settings are registered so every output leaves a flop
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            // pin fields start at the synchroniser's cleared level
            eff_ff <= '{nrzi_en:                 DEF_CODING_OFF,
                        payload_valid_signal_en: ~RST_CODING[CFG_VALID_OFF],
                        scrambler_en:            DEF_CODING_OFF,
                        encoder_bypass:          DEF_CODING_OFF,
                        training_en:             DEF_CODING_OFF,
                        remote_sense_en_n:       1'b0,
                        dc_encoder_en_n:         1'b0,
                        clock_delay_bypass:      RST_CLKDLY[DLY_BYP],
                        channel_reset:           RST_PWR[PWR_CHRST],
                        clock_power_down:        RST_PWR[PWR_CLKPD],
                        parallel_clock_input_en: RST_PWR[PWR_PCLK],
                        parallel_data_lane_en:   RST_PWR[LANES-1:0],
                        deemph_level:            2'h0};
        end else if (ce) begin
            eff_ff <= nxt_eff;
        end
    end

    assign rd_data  = rd_data_ff;
    assign rd_valid = rd_valid_ff;
    assign settings = eff_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_nrzi_locked: assert property (ce && !unl_ff[UNL_NRZI] |=> !eff_ff.nrzi_en) // see R1
        else $error("nrzi active while locked");

    a_nrzi_unlocked: assert property ( // see R8
        ce && unl_ff[UNL_NRZI] |=> eff_ff.nrzi_en == $past(cod_ff[CFG_NRZI]))
        else $error("nrzi does not follow register");

    a_valid_follow: assert property ( // see R2
        ce |=> eff_ff.payload_valid_signal_en == !$past(cod_ff[CFG_VALID_OFF]))
        else $error("payload valid does not follow disable bit");

    a_scram_gate: assert property ( // see R3
        ce |=> eff_ff.scrambler_en ==
            ($past(unl_ff[UNL_SCRAM]) && $past(cod_ff[CFG_SCRAM])))
        else $error("scrambler enable wrong");

    a_bypass_gate: assert property ( // see R4
        ce |=> eff_ff.encoder_bypass ==
            ($past(unl_ff[UNL_BYP]) && $past(cod_ff[CFG_BYP])))
        else $error("encoder bypass wrong");

    a_train_gate: assert property ( // see R5
        ce |=> eff_ff.training_en ==
            ($past(unl_ff[UNL_TRAIN]) && $past(cod_ff[CFG_TRAIN])))
        else $error("training enable wrong");

    a_cfg_from_pins: assert property ( // see R6
        ce && !unl_ff[UNL_PINS]
        |=> {eff_ff.remote_sense_en_n, eff_ff.dc_encoder_en_n} == $past(cfg_pins))
        else $error("config field not from pins");

    a_cfg_from_reg: assert property ( // see R7
        ce && unl_ff[UNL_PINS]
        |=> {eff_ff.remote_sense_en_n, eff_ff.dc_encoder_en_n}
            == $past(cod_ff[CFG_PINS_HI:0]))
        else $error("config field not from register");

    // a write must land even while its unlock bit is clear
    a_locked_store: assert property (ce && wr_cod |=> cod_ff == $past(req.wdata)) // see R9
        else $error("coding write not stored");

    a_delay_bypass: assert property ( // see R10
        ce |=> eff_ff.clock_delay_bypass == $past(dly_ff[DLY_BYP]))
        else $error("clock delay bypass wrong");

    a_chrst_set: assert property ( // see R11
        ce && wr_pwr && req.wdata[PWR_CHRST] |=> pwr_ff[PWR_CHRST])
        else $error("channel reset not set");

    a_chrst_clear: assert property (ce && !wr_pwr |=> !pwr_ff[PWR_CHRST]) // see R11
        else $error("channel reset did not self-clear");

    // the channel sees one pulse per write unless the host re-arms it
    a_chrst_pulse: assert property ( // see R11
        ce && eff_ff.channel_reset && !pwr_ff[PWR_CHRST] |=> !eff_ff.channel_reset)
        else $error("channel reset pulse too long");

    a_clock_pd: assert property ( // see R12
        ce |=> eff_ff.clock_power_down == $past(pwr_ff[PWR_CLKPD]))
        else $error("clock power down wrong");

    a_lane_enable: assert property ( // see R13 see R14
        ce |=> {eff_ff.parallel_clock_input_en, eff_ff.parallel_data_lane_en}
            == $past(pwr_ff[PWR_PCLK:0]))
        else $error("lane enables wrong");

    // these look across reset itself, so the default disable must not apply
    a_reset_values: assert property (disable iff (1'b0) // see R15
        reset |=> pwr_ff == RST_PWR && cod_ff == RST_CODING
            && unl_ff == RST_UNLOCK && dly_ff == RST_CLKDLY && dem_ff == RST_DEEMPH)
        else $error("reset values wrong");

    a_reset_outputs: assert property (disable iff (1'b0) // see R13 see R14
        reset |=> !rd_valid_ff && !eff_ff.channel_reset && !eff_ff.nrzi_en
            && eff_ff.parallel_clock_input_en
            && eff_ff.parallel_data_lane_en == RST_PWR[LANES-1:0])
        else $error("outputs not at reset level");

    a_deemph_sel: assert property ( // see R16
        ce |=> eff_ff.deemph_level ==
            ($past(dem_ff[DEM_OVR]) ? $past(dem_ff[1:0]) : $past(dem_pins)))
        else $error("de-emphasis selection wrong");

    // reserved bits must drop on write so a read never shows stale junk
    a_reserved_zero: assert property ( // see R8 see R10
        unl_ff[7:5] == 3'h0 && dly_ff[6:0] == 7'h00 && dem_ff[7:3] == 5'h00)
        else $error("reserved bit set");

    a_read_unmapped: assert property (ce && req.rd && !hit_any
        |=> rd_valid_ff && rd_data_ff == RD_NONE)
        else $error("unmapped read not zero");

    a_read_pulse: assert property (ce |=> rd_valid_ff == $past(req.rd))
        else $error("read answer not one cycle after request");

    a_unmapped_write: assert property (ce && req.wr && !hit_any
        |=> $stable(cod_ff) && $stable(unl_ff) && $stable(dly_ff) && $stable(dem_ff)
            && $stable(pwr_ff[PWR_CHRST-1:0]))
        else $error("unmapped write changed a register");

    // a low enable freezes everything, read answer included
    a_freeze_state: assert property (!ce |=> $stable(cod_ff) && $stable(unl_ff)
        && $stable(dly_ff) && $stable(pwr_ff) && $stable(dem_ff))
        else $error("register changed while frozen");

    a_freeze_outputs: assert property (!ce
        |=> $stable(eff_ff) && $stable(rd_data_ff) && $stable(rd_valid_ff))
        else $error("output changed while frozen");

endmodule : sco_regs

//--- sco_regs_bench.sv
// sco_regs_bench: self-checking bench for the serializer configuration register bank.
// assumes the host model in sco_host and all inputs driven on the falling edge.
`timescale 1ns/1ps
module sco_regs_bench;
    import sco_pkg::*;

    logic       ref_clk;
    logic       reset;
    logic       ce;
    logic [1:0] cfg_pins;
    logic [1:0] deemph_pins;
    logic [7:0] rd_data;
    logic       rd_valid;
    sco_req_t   req;
    sco_eff_t   settings;
    int         fails;
    int         checked;
    int         cycles;

    // coding view packs nrzi at bit 5 above config bits 4:0 in their register order, power view follows the power register
    wire logic [7:0] coding_eff = {2'b00, settings.nrzi_en, settings.scrambler_en,
        settings.encoder_bypass, settings.training_en, settings.remote_sense_en_n,
        settings.dc_encoder_en_n};
    wire logic [7:0] pwr_eff = {settings.channel_reset, settings.clock_power_down,
        settings.parallel_clock_input_en, settings.parallel_data_lane_en};

    sco_regs i_dut (
        .ref_clk           (ref_clk),
        .reset             (reset),
        .ce                (ce),
        .req               (req),
        .cfg_pins_async    (cfg_pins),
        .deemph_pins_async (deemph_pins),
        .rd_data           (rd_data),
        .rd_valid          (rd_valid),
        .settings          (settings)
    );

    sco_host i_host (
        .ref_clk  (ref_clk),
        .req      (req),
        .rd_data  (rd_data),
        .rd_valid (rd_valid)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        i_host.rd_reg(addr, d, ok);
        chk("read answer", 8'h01, {7'h00, ok});
        chk($sformatf("register %h", addr), exp, d);
    endtask : rd_chk

    // write, then let the output flop and the pin synchronisers catch up
    task automatic wr_settle(input logic [7:0] addr, input logic [7:0] data);
        i_host.wr_reg(addr, data);
        repeat (4) @(negedge ref_clk);
    endtask : wr_settle

    task automatic t_reset_values;
        logic [7:0] ta [6] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h26};
        logic [7:0] te [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3F};
        for (int i = 0; i < 6; i++) rd_chk(ta[i], te[i]);
        chk("coding", 8'h00, coding_eff);
        chk("power", 8'h3F, pwr_eff);
        chk("payload valid", 8'h01, {7'h00, settings.payload_valid_signal_en});
        chk("delay bypass", 8'h00, {7'h00, settings.clock_delay_bypass});
    endtask : t_reset_values

    // writes to holes in the map must not alias onto a neighbour
    task automatic t_unmapped;
        wr_settle(8'h23, 8'hFF);
        wr_settle(8'h25, 8'hFF);
        rd_chk(8'h23, 8'h00);
        rd_chk(ADDR_UNLOCK, 8'h00);
        rd_chk(ADDR_CODING, 8'h00);
        rd_chk(ADDR_PWR, 8'h3F);
        chk("coding hole", 8'h00, coding_eff);
    endtask : t_unmapped

    task automatic t_unlock;
        cfg_pins = 2'b10;
        wr_settle(ADDR_CODING, 8'hBF);
        chk("coding locked", 8'h02, coding_eff);
        rd_chk(ADDR_CODING, 8'hBF);
        for (int i = 1; i <= 4; i++) begin
            wr_settle(ADDR_UNLOCK, 8'h01 << i);
            chk("coding single", (8'h01 << (i + 1)) | 8'h02, coding_eff);
        end
        wr_settle(ADDR_UNLOCK, 8'h01);
        chk("coding pins", 8'h03, coding_eff);
        wr_settle(ADDR_UNLOCK, 8'hFF);
        chk("coding all", 8'h3F, coding_eff);
        rd_chk(ADDR_UNLOCK, 8'h1F);
        wr_settle(ADDR_CODING, 8'h40);
        chk("payload off", 8'h00, {7'h00, settings.payload_valid_signal_en});
        chk("coding cleared", 8'h00, coding_eff);
        wr_settle(ADDR_CODING, 8'h00);
        chk("payload on", 8'h01, {7'h00, settings.payload_valid_signal_en});
    endtask : t_unlock

    task automatic t_clock_delay;
        wr_settle(ADDR_CLKDLY, 8'hFF);
        rd_chk(ADDR_CLKDLY, 8'h80);
        chk("delay bypass", 8'h01, {7'h00, settings.clock_delay_bypass});
        wr_settle(ADDR_CLKDLY, 8'h7F);
        chk("delay insert", 8'h00, {7'h00, settings.clock_delay_bypass});
    endtask : t_clock_delay

    // a frozen block must drop a write and hold its outputs
    task automatic t_freeze;
        ce = 1'b0;
        i_host.wr_reg(ADDR_CLKDLY, 8'h80);
        repeat (2) @(negedge ref_clk);
        chk("frozen bypass", 8'h00, {7'h00, settings.clock_delay_bypass});
        ce = 1'b1;
        rd_chk(ADDR_CLKDLY, 8'h00);
    endtask : t_freeze

    task automatic t_power;
        int pulses;
        pulses = 0;
        i_host.wr_reg(ADDR_PWR, 8'hC0);
        repeat (4) begin
            @(negedge ref_clk);
            if (settings.channel_reset === 1'b1) pulses++;
        end
        chk("reset pulses", 8'h01, 8'(pulses));
        chk("power down", 8'h40, pwr_eff);
        rd_chk(ADDR_PWR, 8'h40);
        wr_settle(ADDR_PWR, 8'h2A);
        chk("lanes", 8'h2A, pwr_eff);
    endtask : t_power

    task automatic t_deemph;
        deemph_pins = 2'b11;
        wr_settle(ADDR_DEEMPH, 8'h01);
        chk("deemph pins", 8'h03, {6'h00, settings.deemph_level});
        wr_settle(ADDR_DEEMPH, 8'hFD);
        rd_chk(ADDR_DEEMPH, 8'h05);
        chk("deemph reg", 8'h01, {6'h00, settings.deemph_level});
    endtask : t_deemph

    // a second reset in mid-run must bring the power, unlock and de-emphasis registers back
    task automatic t_mid_reset;
        reset = 1'b1;
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        chk("power reset", 8'h3F, pwr_eff);
        rd_chk(ADDR_PWR, 8'h3F);
        rd_chk(ADDR_UNLOCK, 8'h00);
        rd_chk(ADDR_DEEMPH, 8'h00);
        repeat (4) @(negedge ref_clk);
        chk("coding after reset", 8'h02, coding_eff);
        chk("deemph after reset", 8'h03, {6'h00, settings.deemph_level});
    endtask : t_mid_reset

    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", fails, checked);
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // the whole sequence needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            tally_and_finish();
        end
    end

    initial begin
        fails       = 0;
        checked     = 0;
        cycles      = 0;
        reset       = 1'b1;
        ce          = 1'b1;
        cfg_pins    = 2'b00;
        deemph_pins = 2'b00;
        repeat (8) @(negedge ref_clk);
        reset = 1'b0;
        t_reset_values();
        t_unmapped();
        t_unlock();
        t_clock_delay();
        t_freeze();
        t_power();
        t_deemph();
        t_mid_reset();
        tally_and_finish();
    end
endmodule : sco_regs_bench

//--- sco_select.sv
// sco_select: picks the register value when unlocked, else the pin or default value.
// assumes a purely combinational use inside the register bank.
`timescale 1ns/1ps
module sco_select #(
    parameter int unsigned W = 1
) (
    input  wire logic         unlock,
    input  wire logic [W-1:0] reg_val,
    input  wire logic [W-1:0] pin_val,
    output logic      [W-1:0] eff_val
);
    assign eff_val = unlock ? reg_val : pin_val;
endmodule : sco_select

//--- sco_sync.sv
// sco_sync: two-flop synchroniser for slow configuration pins.
// assumes pins change rarely; multi-bit skew settles within a cycle.
`timescale 1ns/1ps
module sco_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else if (ce) begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule : sco_sync
